// File: core/dir_exec_pkg.sv
// Constants and types shared by the director execution block
package dir_exec_pkg;
  // Register byte offsets (haddr[7:0])
  localparam logic [7:0] OFF_DIRECTOR   = 8'h00;
  localparam logic [7:0] OFF_COMMAND    = 8'h04;
  localparam logic [7:0] OFF_CONFIG     = 8'h08;
  localparam logic [7:0] OFF_STATUS0    = 8'h0c;
  localparam logic [7:0] OFF_STATUS1    = 8'h10;
  localparam logic [7:0] OFF_BYTE_COUNT = 8'h14;
  localparam logic [7:0] OFF_RF_COUNT   = 8'h18;
  localparam logic [1:0] RF_WINDOW      = 2'h1;   // haddr[7:6] of 0x40..0x7c
  // Director word bit positions
  localparam int DIR_SAVE       = 6;
  localparam int DIR_MARK_START = 8;
  localparam int DIR_HALF       = 9;
  localparam int DIR_RF_SRC     = 10;
  localparam int DIR_MATCH_EN   = 13;
  localparam int DIR_CNT_FROM_RF = 15;
  localparam int DIR_COUNT_LSB  = 16;
  // Command register bits
  localparam int CMD_COMPARE = 0;
  localparam int CMD_DELAY   = 1;
  localparam int CMD_SUPPORT = 2;
  localparam int CMD_ABORT   = 3;
  // Config and status bit positions
  localparam int CFG_EIGHT_BIT   = 0;
  localparam int ST0_COMPARE     = 3;
  localparam int ST0_DONE        = 11;
  localparam int ST0_NOT_MET     = 12;
  // Mark condition codes
  localparam logic [1:0] MARK_INDEX  = 2'h0;
  localparam logic [1:0] MARK_SECTOR = 2'h1;
  localparam logic [1:0] MARK_ALERT  = 2'h2;
  // Bit counter positions
  localparam logic [3:0] BIT_ONE   = 4'h1;
  localparam logic [3:0] BIT_THREE = 4'h3;
  localparam logic [3:0] BIT_FOUR  = 4'h4;
  localparam logic [3:0] BIT_FIVE  = 4'h5;
  localparam logic [3:0] BITS_8    = 4'h8;
  localparam logic [3:0] BITS_6    = 4'h6;
  // Delay byte counter tick spacing
  localparam logic [2:0] TICK_8BIT = 3'h7;
  localparam logic [2:0] TICK_6BIT = 3'h5;
  // Register file geometry and reset values
  localparam int RF_AW = 4;
  localparam int RF_DW = 16;
  localparam logic [31:0] WORD_RESET = 32'h0;
  localparam logic [15:0] COUNT_RESET = 16'h0;
  // Execution states
  typedef enum logic [1:0] {st_idle, st_compare, st_delay} exec_state_e;
endpackage

// File: core/pin_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin,
  output var  logic [W-1:0] pin_sync_q
);
  logic [W-1:0] stage1;  // Metastability catcher, read only below

  // Two flip-flops in series
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1     <= '0;
      pin_sync_q <= '0;
    end else begin
      stage1     <= pin;
      pin_sync_q <= stage1;
    end
  end
endmodule
`default_nettype wire

// File: core/rf_mem.sv
// Register file holding compare words and counts, registered read
`timescale 1ns/100ps
`default_nettype none
module rf_mem (
  input  wire logic                          ref_clk,
  input  wire logic                          wr_en,
  input  wire logic [dir_exec_pkg::RF_AW-1:0] wr_addr,
  input  wire logic [dir_exec_pkg::RF_DW-1:0] wr_data,
  input  wire logic [dir_exec_pkg::RF_AW-1:0] rd_addr,
  output var  logic [dir_exec_pkg::RF_DW-1:0] rd_data
);
  logic [dir_exec_pkg::RF_DW-1:0] mem [2**dir_exec_pkg::RF_AW];  // Storage

  // Write port
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read data from a register, follows the counter one cycle late
  always_ff @(posedge ref_clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// File: core/dir_exec.sv
// Compare and delay director execution with AHB-Lite registers
// Functional notes
// R1 - RF compare: half flag copied at count one
// R2 - Half flag clear compares upper, set lower
// R3 - RF compare: lost-data check at count three
// R4 - Count four toggles the half-select flag
// R5 - Count four latches mismatch into not-met
// R6 - Count four decrements byte counter by one
// R7 - Count one before decrement terminates compare
// R8 - RF compare: count five lower advances RF counter
// R9 - Otherwise continue with next byte
// R10 - Bits 6 and 10 clear: buffer source
// R11 - Buffer compare: count one clears count-from-RF
// R12 - Buffer compare: lower and rank4 full clears it
// R13 - Delay lasts count plus one byte
// R14 - Support directors run during delay
// R15 - Source stages next director during delay; here director writes are ignored outside st_idle
// R16 - Mark start waits for mark before counting
// R17 - Bits 9,10 pick index, sector, alert
// R18 - Host selects read status before mark delay
// R19 - Delay start sets flag, blocks, loads count
// R20 - Mark start loads sector length, holds counter
// R21 - Byte tick every five or seven counts
// R22 - At zero wait one tick, then done
// R23 - Termination sets done and compare status
// R24 - Not-met is mismatch gated by bit 13
// R25 - Reset clears flags and execution
`timescale 1ns/100ps
`default_nettype none
module dir_exec (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic        read_shift_clock,
  input  wire logic        read_data,
  input  wire logic        index_mark,
  input  wire logic        sector_mark,
  input  wire logic        sector_alert,
  input  wire logic        rank4_full,
  input  wire logic [15:0] buffer_word,
  output var  logic        director_done,
  output var  logic        data_count_done,
  output var  logic        byte_count_decrement,
  output var  logic        half_toggle_pulse,
  output var  logic        clear_rank4_full,
  output var  logic        compare_done_not_met,
  output var  logic        transfer_block,
  output var  logic        sector_length_load,
  output var  logic        support_director_go,
  output var  logic        lost_data_fault,
  output var  logic        force_eight_bit,
  output var  logic        delay_finished
);
  dir_exec_pkg::exec_state_e state;  // Execution state
  logic [31:0] director;            // Director word
  logic        cfg_eight_bit;       // Software 8-bit mode
  logic        wr_pend;             // Write data phase pending
  logic [7:0]  wr_addr;             // Address of pending write
  logic [4:0]  pins_s;              // Synchronised pins
  logic [4:0]  pins_d;              // Previous synchronised pins
  logic        shift_edge;          // Rising read shift clock
  logic [3:0]  bit_cnt;             // Bit counter
  logic [7:0]  shift_reg;           // Serial read data
  logic [7:0]  catch_reg;           // Byte caught at count three
  logic [15:0] byte_count;          // Byte counter
  logic [3:0]  rf_count;            // Register file counter
  logic [15:0] rf_rdata;            // Register file read data
  logic        rf_src;              // Latched bit 10
  logic        match_en;            // Latched bit 13
  logic        half_sel;            // Half select flip-flop
  logic        lower_half_active;   // Upper/lower flip-flop
  logic        cnt_from_rf;         // Load byte counter from RF flag
  logic        compare_done;        // Compare done flip-flop
  logic        compare_not_met;     // Compare not met flip-flop
  logic        compare_status;      // Compare status
  logic        lost_data;           // Lost data flip-flop
  logic        delay_active;        // Delay flip-flop
  logic        mark_start;          // Mark start flip-flop
  logic [1:0]  mark_sel;            // Latched bits 9 and 10
  logic [2:0]  dly_cnt;             // Delay byte counter
  logic        in_cmp;              // Compare running
  logic        ev1, ev3, ev4, ev5;  // Bit count events
  logic        eight_bit_mode;      // Effective 8-bit mode
  logic        compare_half_select; // High selects upper half
  logic [7:0]  compare_byte;        // Selected compare half
  logic        not_met_sig;         // Gated mismatch
  logic        byte_count_is_one;   // Counter at one
  logic        byte_count_zero;     // Counter at zero
  logic        terminate;           // Compare ends this byte
  logic        lost_now;            // Lost data detected
  logic        delay_byte_tick;     // Byte tick from delay counter
  logic        delay_count_clock;   // Delay decrement strobe
  logic        delay_end;           // Delay expires
  logic        mark_hit;            // Selected mark leading edge
  logic        cmd_wr;              // Command register write
  logic        start_compare;       // Compare director begins
  logic        start_delay;         // Delay director begins
  logic        abort;               // Software abort
  logic        ahb_go;              // Address phase accepted
  logic [31:0] rd_word;             // Read mux output

  // Bit count event with the shift clock
  function automatic logic at_count(input logic edge_q, input logic [3:0] cnt,
                                    input logic [3:0] pos);
    at_count = edge_q && (cnt == pos);
  endfunction

  // Pick the mark selected by the latched code
  function automatic logic mark_pick(input logic [1:0] sel, input logic [2:0] m);
    unique case (sel)
      dir_exec_pkg::MARK_INDEX:  mark_pick = m[0];
      dir_exec_pkg::MARK_SECTOR: mark_pick = m[1];
      dir_exec_pkg::MARK_ALERT:  mark_pick = m[2];
      default:                   mark_pick = 1'b0;  // Unused code never fires
    endcase
  endfunction

  // Pins: shift clock, data, index, sector, alert
  pin_sync #(.W(5)) u_sync (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .pin        ({sector_alert, sector_mark, index_mark, read_data, read_shift_clock}),
    .pin_sync_q (pins_s)
  );

  // Register file, written by software, read at the RF counter
  rf_mem u_rf (
    .ref_clk (ref_clk),
    .wr_en   (wr_pend && (wr_addr[7:6] == dir_exec_pkg::RF_WINDOW)),
    .wr_addr (wr_addr[5:2]),
    .wr_data (hwdata[15:0]),
    .rd_addr (rf_count),
    .rd_data (rf_rdata)
  );

  // Combinational decode of events and compare path
  always_comb begin
    shift_edge          = pins_s[0] && !pins_d[0];
    in_cmp              = (state == dir_exec_pkg::st_compare);
    ev1                 = in_cmp && at_count(shift_edge, bit_cnt, dir_exec_pkg::BIT_ONE);
    ev3                 = in_cmp && at_count(shift_edge, bit_cnt, dir_exec_pkg::BIT_THREE);
    ev4                 = in_cmp && at_count(shift_edge, bit_cnt, dir_exec_pkg::BIT_FOUR);
    ev5                 = in_cmp && at_count(shift_edge, bit_cnt, dir_exec_pkg::BIT_FIVE);
    eight_bit_mode      = cfg_eight_bit || force_eight_bit;
    compare_half_select = !lower_half_active;                                   // R2
    compare_byte        = compare_half_select ? (rf_src ? rf_rdata[15:8] : buffer_word[15:8])
                                              : (rf_src ? rf_rdata[7:0] : buffer_word[7:0]);
    not_met_sig         = (catch_reg != compare_byte) && match_en;              // R24
    byte_count_is_one   = (byte_count == 16'h0001);
    byte_count_zero     = (byte_count == 16'h0000);
    terminate           = ev4 && byte_count_is_one;                             // R7
    lost_now            = ev3 && rf_src && !rank4_full;                         // R3
    delay_byte_tick     = delay_active && !mark_start && shift_edge &&
                          (dly_cnt == ((eight_bit_mode ? dir_exec_pkg::TICK_8BIT
                                                      : dir_exec_pkg::TICK_6BIT) - 3'h1));
    delay_count_clock   = delay_byte_tick && !byte_count_zero;                  // R21
    delay_end           = delay_byte_tick && byte_count_zero;                   // R22
    mark_hit            = mark_start && mark_pick(mark_sel, pins_s[4:2]) &&
                          !mark_pick(mark_sel, pins_d[4:2]);                    // R17
    ahb_go              = hsel && htrans[1] && hready;
    cmd_wr              = wr_pend && (wr_addr == dir_exec_pkg::OFF_COMMAND);
    abort               = cmd_wr && hwdata[dir_exec_pkg::CMD_ABORT];
    // Bit 6 alone is compare-and-save, not handled here
    start_compare       = cmd_wr && (state == dir_exec_pkg::st_idle) &&
                          hwdata[dir_exec_pkg::CMD_COMPARE] &&
                          !(director[dir_exec_pkg::DIR_SAVE] &&
                            !director[dir_exec_pkg::DIR_RF_SRC]);               // R10
    start_delay         = cmd_wr && (state == dir_exec_pkg::st_idle) &&
                          !hwdata[dir_exec_pkg::CMD_COMPARE] &&
                          hwdata[dir_exec_pkg::CMD_DELAY];
  end

  // Previous pin levels for edge detection
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pins_d <= 5'h00;
    end else begin
      pins_d <= pins_s;
    end
  end

  // Execution state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= dir_exec_pkg::st_idle;  // R25
    end else begin
      unique case (state)
        dir_exec_pkg::st_idle: begin
          if (start_compare) begin
            state <= dir_exec_pkg::st_compare;
          end else if (start_delay) begin
            state <= dir_exec_pkg::st_delay;
          end
        end
        dir_exec_pkg::st_compare: begin
          if (terminate || lost_now || abort) begin
            state <= dir_exec_pkg::st_idle;  // R7
          end
        end
        dir_exec_pkg::st_delay: begin
          if (delay_end || abort) begin
            state <= dir_exec_pkg::st_idle;  // R22
          end
        end
      endcase
    end
  end

  // Bit counter and serial byte assembly
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bit_cnt   <= dir_exec_pkg::BIT_ONE;
      shift_reg <= 8'h00;
      catch_reg <= 8'h00;
    end else begin
      if (start_compare) begin
        bit_cnt <= dir_exec_pkg::BIT_ONE;
      end else if (shift_edge) begin
        // Wrap after the last bit of the byte; next byte starts at one
        if (bit_cnt >= (eight_bit_mode ? dir_exec_pkg::BITS_8 : dir_exec_pkg::BITS_6)) begin
          bit_cnt <= dir_exec_pkg::BIT_ONE;  // R9
        end else begin
          bit_cnt <= bit_cnt + 4'h1;
        end
      end
      if (shift_edge) begin
        shift_reg <= {shift_reg[6:0], pins_s[1]};
      end
      if (ev3) begin
        catch_reg <= shift_reg;
      end
    end
  end

  // Compare latches, half selection and termination flags
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rf_src            <= 1'b0;
      match_en          <= 1'b0;
      half_sel          <= 1'b0;
      lower_half_active <= 1'b0;
      cnt_from_rf       <= 1'b0;
      compare_done      <= 1'b0;  // R25
      compare_not_met   <= 1'b0;  // R25
      compare_status    <= 1'b0;
      force_eight_bit   <= 1'b0;
      lost_data         <= 1'b0;
    end else begin
      if (start_compare) begin
        rf_src          <= director[dir_exec_pkg::DIR_RF_SRC];
        match_en        <= director[dir_exec_pkg::DIR_MATCH_EN];
        half_sel        <= director[dir_exec_pkg::DIR_HALF];
        cnt_from_rf     <= director[dir_exec_pkg::DIR_CNT_FROM_RF];
        compare_done    <= 1'b0;
        compare_not_met <= 1'b0;
        compare_status  <= 1'b0;
        force_eight_bit <= 1'b0;
        lost_data       <= 1'b0;
      end else begin
        if (ev1) begin
          lower_half_active <= half_sel;  // R1
        end
        if (ev1 && !rf_src) begin
          cnt_from_rf <= 1'b0;  // R11
        end
        if (ev4) begin
          half_sel <= !half_sel;  // R4
        end
        if (ev4 && not_met_sig) begin
          compare_not_met <= 1'b1;  // R5
        end
        if (terminate) begin
          compare_done    <= 1'b1;  // R23
          compare_status  <= 1'b1;  // R23
          force_eight_bit <= 1'b1;  // R7
        end
        if (lost_now) begin
          lost_data <= 1'b1;  // R3
        end
      end
    end
  end

  // Byte counter: loaded by a director, decremented per byte
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      byte_count <= dir_exec_pkg::COUNT_RESET;
    end else if (start_compare) begin
      byte_count <= director[dir_exec_pkg::DIR_CNT_FROM_RF] ? rf_rdata
                    : director[31:dir_exec_pkg::DIR_COUNT_LSB];
    end else if (start_delay) begin
      byte_count <= director[31:dir_exec_pkg::DIR_COUNT_LSB];  // R19
    end else if (ev4 || delay_count_clock) begin
      byte_count <= byte_count - 16'h0001;  // R6
    end
  end

  // Register file counter: software preset, lower-half advance
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rf_count <= 4'h0;
    end else if (wr_pend && (wr_addr == dir_exec_pkg::OFF_RF_COUNT)) begin
      rf_count <= hwdata[3:0];
    end else if (ev5 && rf_src && lower_half_active) begin
      rf_count <= rf_count + 4'h1;  // R8
    end
  end

  // Delay and mark start flip-flops, delay byte counter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      delay_active <= 1'b0;  // R25
      mark_start   <= 1'b0;  // R25
      mark_sel     <= 2'h0;
      dly_cnt      <= 3'h0;
    end else begin
      if (start_delay) begin
        delay_active <= 1'b1;                                    // R19
        mark_sel     <= director[dir_exec_pkg::DIR_RF_SRC:dir_exec_pkg::DIR_HALF];
        mark_start   <= director[dir_exec_pkg::DIR_MARK_START];  // R16
      end else if (delay_end || abort) begin
        delay_active <= 1'b0;
        mark_start   <= 1'b0;
      end else if (mark_hit) begin
        mark_start <= 1'b0;  // R20
      end
      // Held cleared while a mark is awaited
      if (!delay_active || mark_start || delay_byte_tick) begin
        dly_cnt <= 3'h0;  // R20
      end else if (shift_edge) begin
        dly_cnt <= dly_cnt + 3'h1;  // R21
      end
    end
  end

  // Registered event outputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      director_done        <= 1'b0;
      data_count_done      <= 1'b0;
      byte_count_decrement <= 1'b0;
      half_toggle_pulse    <= 1'b0;
      clear_rank4_full     <= 1'b0;
      compare_done_not_met <= 1'b0;
      transfer_block       <= 1'b0;
      sector_length_load   <= 1'b0;
      support_director_go  <= 1'b0;
      lost_data_fault      <= 1'b0;
      delay_finished       <= 1'b0;
    end else begin
      director_done        <= terminate || delay_end;                       // R22
      data_count_done      <= terminate;                                    // R7
      byte_count_decrement <= ev4 || delay_count_clock;                     // R6
      half_toggle_pulse    <= ev4;                                          // R4
      clear_rank4_full     <= ev4 && !rf_src && lower_half_active &&
                              rank4_full;                                   // R12
      compare_done_not_met <= (compare_not_met || (ev4 && not_met_sig)) &&
                              !start_compare;                               // R5
      transfer_block       <= (start_delay || delay_active) &&
                              !(delay_end || abort);                        // R19
      sector_length_load   <= start_delay && director[dir_exec_pkg::DIR_MARK_START];  // R20
      support_director_go  <= cmd_wr && hwdata[dir_exec_pkg::CMD_SUPPORT] &&
                              (state != dir_exec_pkg::st_compare);          // R14
      lost_data_fault      <= lost_data || lost_now;
      delay_finished       <= delay_end;                                    // R13
    end
  end

  // Software-written registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      director      <= dir_exec_pkg::WORD_RESET;
      cfg_eight_bit <= 1'b0;
    end else if (wr_pend) begin
      if (wr_addr == dir_exec_pkg::OFF_DIRECTOR && state == dir_exec_pkg::st_idle) begin
        director <= hwdata;  // Locked while a director runs
      end
      if (wr_addr == dir_exec_pkg::OFF_CONFIG) begin
        cfg_eight_bit <= hwdata[dir_exec_pkg::CFG_EIGHT_BIT];
      end
    end
  end

  // Read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (haddr[7:0])
      dir_exec_pkg::OFF_DIRECTOR:   rd_word = director;
      dir_exec_pkg::OFF_CONFIG:     rd_word = {31'h0, cfg_eight_bit};
      dir_exec_pkg::OFF_STATUS0: begin
        rd_word[dir_exec_pkg::ST0_COMPARE] = compare_status;   // R23
        rd_word[dir_exec_pkg::ST0_DONE]    = compare_done;     // R23
        rd_word[dir_exec_pkg::ST0_NOT_MET] = compare_not_met;  // R5
      end
      dir_exec_pkg::OFF_STATUS1:
        rd_word = {23'h0, half_sel, lower_half_active, cnt_from_rf, lost_data,
                   force_eight_bit, mark_start, delay_active, (state != dir_exec_pkg::st_idle)};
      dir_exec_pkg::OFF_BYTE_COUNT: rd_word = {16'h0, byte_count};
      dir_exec_pkg::OFF_RF_COUNT:   rd_word = {28'h0, rf_count};
      default:                      rd_word = 32'h0000_0000;
    endcase
  end

  // AHB-Lite slave: zero wait states, always OKAY
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend   <= ahb_go && hwrite;
      wr_addr   <= haddr[7:0];
      hrdata    <= (ahb_go && !hwrite) ? rd_word : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: sim/dir_exec_checker.sv
// Assertions on the director block's ports
`timescale 1ns/100ps
`default_nettype none
module dir_exec_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic director_done,
  input wire logic delay_finished,
  input wire logic data_count_done,
  input wire logic byte_count_decrement,
  input wire logic half_toggle_pulse,
  input wire logic clear_rank4_full,
  input wire logic transfer_block
);
  // One clock domain, reset disables every check
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_bus_ready: assert property (hreadyout)
    else $error("hreadyout low");
  a_bus_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_delay_end: assert property (delay_finished |-> director_done)
    else $error("delay end without done");
  a_cmp_end: assert property (data_count_done |-> director_done)
    else $error("count done without done");
  a_toggle_dec: assert property (half_toggle_pulse |-> byte_count_decrement)
    else $error("toggle without decrement");
  a_rank4_four: assert property (clear_rank4_full |-> half_toggle_pulse)
    else $error("rank clear off count four");
  a_delay_held: assert property (delay_finished |-> $past(transfer_block))
    else $error("delay end without block");
  a_done_pulse: assert property (director_done |=> !director_done)
    else $error("done longer than a cycle");
endmodule
`default_nettype wire

// File: sim/disk_model.sv
// Disk read channel model: shift clock, serial data and marks
`timescale 1ns/100ps
`default_nettype none
module disk_model (
  input  wire logic       ref_clk,
  input  wire logic       run,
  input  wire logic       bitv,
  input  wire logic [1:0] mark_sel,
  input  wire logic       mark_go,
  output var  logic       read_shift_clock,
  output var  logic       read_data,
  output var  logic       index_mark,
  output var  logic       sector_mark,
  output var  logic       sector_alert
);
  logic [1:0] ph; // Half-period divider
  // Shift clock toggles every four cycles while reading, low otherwise
  always_ff @(posedge ref_clk) begin
    ph <= run ? ph + 2'h1 : 2'h0;
    read_shift_clock <= run && (ph == 2'h3 ? !read_shift_clock : read_shift_clock);
  end
  // Idle data line shows the inverse level
  always_comb read_data = run ? bitv : !bitv;
  // Only the chosen mark line rises
  always_comb index_mark = mark_go && mark_sel == 2'h0;
  always_comb sector_mark = mark_go && mark_sel == 2'h1;
  always_comb sector_alert = mark_go && mark_sel == 2'h2;
endmodule
`default_nettype wire

// File: sim/dir_exec_tb.sv
// Self-checking bench for the director execution block
`timescale 1ns/100ps
`default_nettype none
module dir_exec_tb;
  logic ref_clk = '0, rst = 1'h1, hsel = '0, hwrite = '0, run = '0, bitv = '0;
  logic mark_go = '0, rank4_full = '0;
  logic [1:0] htrans = '0, mark_sel = '0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
  logic [15:0] buffer_word = '0;
  logic hreadyout, hresp, shclk, rdat, im, sm, sa, dd, dec, clr, nm, blk, sll, sup, f8, lf;
  int mismatches = 0, n_compared = 0, cnt[5], t;
  dir_exec dut (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .read_shift_clock(shclk),
    .read_data(rdat), .index_mark(im), .sector_mark(sm), .sector_alert(sa), .rank4_full,
    .buffer_word, .director_done(dd), .data_count_done(), .byte_count_decrement(dec),
    .half_toggle_pulse(), .clear_rank4_full(clr), .compare_done_not_met(nm),
    .transfer_block(blk), .sector_length_load(sll), .support_director_go(sup),
    .lost_data_fault(lf), .force_eight_bit(f8), .delay_finished());
  disk_model dm (.ref_clk, .run, .bitv, .mark_sel, .mark_go, .read_shift_clock(shclk),
    .read_data(rdat), .index_mark(im), .sector_mark(sm), .sector_alert(sa));
  initial forever #5 ref_clk = ~ref_clk;
  // Pulse counters
  always @(posedge ref_clk) begin
    cnt[0] += dd;
    cnt[1] += dec;
    cnt[2] += clr;
    cnt[3] += sll;
    cnt[4] += sup;
  end
  task chk(input logic [31:0] g, e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Single AHB-Lite word transfer, read data left in q
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask
  // Bounded wait for a done pulse
  task wd;
    for (t = 0; t < 4000 && cnt[0] == 0; t++) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task clr_cnt;
    @(negedge ref_clk);
    cnt = '{default:0};
  endtask
  // Two-byte compare, data line all zeros
  task cmp(input logic [31:0] dir, input logic e);
    clr_cnt();
    bus(1'h1, 8'h00, dir);
    bus(1'h1, 8'h04, 32'h1);
    wd();
    chk(cnt[0], 1);
    chk(cnt[1], 2);
    chk(cnt[2], !dir[10]);
    chk(nm, e);
    chk(f8, 1'h1);
    bus(1'h0, 8'h0c, 32'h0);
    chk(q, {e, 12'h808});
    bus(1'h0, 8'h18, 32'h0);
    chk(q, dir[10]);
  endtask
  task lost;
    rank4_full <= 1'h0;
    bus(1'h1, 8'h04, 32'h1);
    repeat (99) @(posedge ref_clk);
    chk(lf, 1'h1);
  endtask
  // Three-byte delay (count of two) with a support director inside it
  task dly;
    clr_cnt();
    bus(1'h1, 8'h00, 32'h0002_0000);
    bus(1'h1, 8'h04, 32'h2);
    bus(1'h1, 8'h04, 32'h4);
    chk(blk, 1'h1);
    wd();
    chk(cnt[4], 1);
    chk(cnt[1], 2);
    chk(t > 140 && t < 180, 1);
  endtask
  // Mark-start delay of zero count on the chosen mark
  task mark(input logic [1:0] c);
    clr_cnt();
    mark_sel <= c;
    bus(1'h1, 8'h00, {21'h0, c, 9'h100});
    bus(1'h1, 8'h04, 32'h2);
    repeat (200) @(posedge ref_clk);
    chk(cnt[0], 0);
    chk(cnt[3], 1);
    mark_go <= 1'h1;
    repeat (4) @(posedge ref_clk);
    mark_go <= 1'h0;
    wd();
    chk(cnt[0], 1);
  endtask
  task print_verdict;
    if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    #100us;
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'h0;
    run <= 1'h1;
    rank4_full <= 1'h1;
    buffer_word <= 16'hffff;
    @(posedge ref_clk);
    chk({dd, blk, nm, f8}, 32'h0);
    bus(1'h1, 8'h08, 32'h1);
    cmp(32'h0002_2000, 1'h1);
    cmp(32'h0002_0000, 1'h0);
    cmp(32'h0002_0600, 1'h0);
    lost();
    dly();
    for (int c = 0; c < 3; c++) mark(c[1:0]);
    print_verdict();
  end
endmodule
bind dir_exec dir_exec_checker chk_i (.ref_clk, .rst, .hreadyout, .hresp, .director_done,
  .delay_finished, .data_count_done, .byte_count_decrement, .half_toggle_pulse,
  .clear_rank4_full, .transfer_block);
`default_nettype wire
